// ---- verilog/hrp_device.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "hrp_params.svh"

module hrp_device
  import hrp_pkg::*;
#(
  parameter int DATA_W = `HRP_DATA_W,
  parameter int ADDR_W = `HRP_ADDR_W,
  parameter int REG_DEPTH = `HRP_REG_DEPTH
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Host facing pins
  hrp_bus_if.dev bus,
  // Local write port into the register space
  input wire logic user_wr_valid,
  input wire logic [ADDR_W-1:0] user_wr_addr,
  input wire logic [DATA_W-1:0] user_wr_data,
  // Local read port of the register space
  input wire logic [ADDR_W-1:0] user_rd_addr,
  output logic [DATA_W-1:0] user_rd_data,
  // Host access reports
  output logic host_wr_valid,
  output logic [ADDR_W-1:0] host_wr_addr,
  output logic [DATA_W-1:0] host_wr_data,
  output logic host_rd_valid,
  output logic [ADDR_W-1:0] host_rd_addr
);

  localparam int IDX_W = (REG_DEPTH > 1) ? $clog2(REG_DEPTH) : 1;
  localparam logic [ADDR_W:0] DEPTH_L = (ADDR_W + 1)'(REG_DEPTH);

  // ----------------------------------------
  // Parameter checks
  // ----------------------------------------
  if (DATA_W != `HRP_DATA_W) begin : g_bad_width
    $error("hrp_device: data width must be eight");
  end
  if (REG_DEPTH < 2 || REG_DEPTH > (1 << ADDR_W)) begin : g_bad_depth
    $error("hrp_device: register depth out of range");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    hrp_dev_phase_t phase;
    logic [DATA_W-1:0] data_out;
    logic data_oe;
    logic [REG_DEPTH-1:0][DATA_W-1:0] regs;
    logic [DATA_W-1:0] user_rd_data;
    logic host_wr_valid;
    logic [ADDR_W-1:0] host_wr_addr;
    logic [DATA_W-1:0] host_wr_data;
    logic host_rd_valid;
    logic [ADDR_W-1:0] host_rd_addr;
  } hrp_dev_state_t;

  hrp_dev_state_t s;
  hrp_dev_state_t next_s;

  logic cs;
  logic rd_act;
  logic wr_act;
  logic wr_rise;
  logic host_mapped;
  logic user_wr_mapped;
  logic user_rd_mapped;
  logic [IDX_W-1:0] host_idx;
  logic [IDX_W-1:0] user_wr_idx;
  logic [IDX_W-1:0] user_rd_idx;
  logic [DATA_W-1:0] rd_val;

  // ----------------------------------------
  // Strobe decoding
  // ----------------------------------------
  always_comb begin
    cs = !bus.chip_select_n; // R3
    if (bus.bus_style_select == `HRP_STYLE_COMBINED) begin
      // Data strobe on the read pin, read-not-write on the write pin
      rd_act = cs && !bus.read_strobe_n && bus.write_strobe_n; // R8
      wr_act = cs && !bus.read_strobe_n && !bus.write_strobe_n; // R8
    end else begin
      rd_act = cs && !bus.read_strobe_n; // R8
      wr_act = cs && !bus.write_strobe_n; // R8
    end
    // Strobe released while chip select still low
    wr_rise = (s.phase == HRP_DEV_WRITE) && cs && !wr_act; // R5
  end

  // ----------------------------------------
  // Address decoding
  // ----------------------------------------
  always_comb begin
    host_mapped = ({1'b0, bus.addr} < DEPTH_L);
    user_wr_mapped = ({1'b0, user_wr_addr} < DEPTH_L);
    user_rd_mapped = ({1'b0, user_rd_addr} < DEPTH_L);
    host_idx = bus.addr[IDX_W-1:0];
    user_wr_idx = user_wr_addr[IDX_W-1:0];
    user_rd_idx = user_rd_addr[IDX_W-1:0];
    if (host_mapped) begin
      rd_val = s.regs[host_idx]; // R4
    end else begin
      rd_val = `HRP_UNMAPPED_RD;
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_s = s;
    next_s.host_wr_valid = 1'b0;
    next_s.host_rd_valid = 1'b0;

    // Access phase tracking
    case (s.phase)
      HRP_DEV_IDLE: begin
        if (rd_act) begin
          next_s.phase = HRP_DEV_READ;
          next_s.host_rd_valid = 1'b1;
          next_s.host_rd_addr = bus.addr;
        end else if (wr_act) begin
          next_s.phase = HRP_DEV_WRITE;
        end
      end
      HRP_DEV_READ: begin
        if (!rd_act) begin
          next_s.phase = HRP_DEV_IDLE;
        end
      end
      HRP_DEV_WRITE: begin
        if (!wr_act) begin
          next_s.phase = HRP_DEV_IDLE;
        end
      end
      default: begin
        next_s.phase = HRP_DEV_IDLE;
      end
    endcase

    // Read data driven only during a qualified read
    if (rd_act) begin
      next_s.data_oe = 1'b1; // R4
      next_s.data_out = rd_val; // R4 R2
    end else begin
      next_s.data_oe = 1'b0; // R6
      next_s.data_out = `HRP_UNMAPPED_RD;
    end

    // Local writes first so a host write to the same entry wins
    if (user_wr_valid && user_wr_mapped) begin
      next_s.regs[user_wr_idx] = user_wr_data;
    end
    if (wr_rise) begin
      next_s.host_wr_valid = 1'b1;
      next_s.host_wr_addr = bus.addr;
      next_s.host_wr_data = bus.data_bus; // R5 R1
      if (host_mapped) begin
        next_s.regs[host_idx] = bus.data_bus; // R5 R2
      end
    end

    // Local readback
    if (user_rd_mapped) begin
      next_s.user_rd_data = s.regs[user_rd_idx];
    end else begin
      next_s.user_rd_data = `HRP_UNMAPPED_RD;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s.phase <= HRP_DEV_IDLE;
      s.data_out <= `HRP_UNMAPPED_RD;
      s.data_oe <= 1'b0;
      s.regs <= {REG_DEPTH{`HRP_REG_RESET}};
      s.user_rd_data <= `HRP_UNMAPPED_RD;
      s.host_wr_valid <= 1'b0;
      s.host_wr_addr <= '0;
      s.host_wr_data <= '0;
      s.host_rd_valid <= 1'b0;
      s.host_rd_addr <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign bus.dev_data = s.data_out;
  assign bus.dev_oe = s.data_oe;
  assign user_rd_data = s.user_rd_data;
  assign host_wr_valid = s.host_wr_valid;
  assign host_wr_addr = s.host_wr_addr;
  assign host_wr_data = s.host_wr_data;
  assign host_rd_valid = s.host_rd_valid;
  assign host_rd_addr = s.host_rd_addr;

endmodule

`default_nettype wire

// ---- verilog/hrp_params.svh ----
// Summary of operation
// (R1) One shared eight-bit two-way data bus
// (R2) Bit seven most significant, bit zero least
// (R3) Strobes count only while chip select low
// (R4) Read: device drives addressed register contents
// (R5) Write captured at strobe rising edge
// (R6) Device releases bus outside qualified read
// (R7) Host presents thirteen-bit register address
// (R8) Style select picks strobe pin meaning
`ifndef HRP_PARAMS_SVH
`define HRP_PARAMS_SVH

// ----------------------------------------
// Pin widths
// ----------------------------------------
`define HRP_DATA_W 8
`define HRP_ADDR_W 13

// ----------------------------------------
// Register space held by the device end
// ----------------------------------------
`define HRP_REG_DEPTH 256
`define HRP_REG_RESET 8'h00
`define HRP_UNMAPPED_RD 8'h00
`define HRP_BUS_IDLE 8'hff

// ----------------------------------------
// Host access timing in core_clk cycles
// ----------------------------------------
`define HRP_SETUP_CYC 1
`define HRP_STROBE_CYC 4
`define HRP_HOLD_CYC 1
`define HRP_STROBE_MIN 2

// ----------------------------------------
// Bus style encodings
// ----------------------------------------
`define HRP_STYLE_SEPARATE 1'b0
`define HRP_STYLE_COMBINED 1'b1

`endif

// ---- verilog/hrp_pkg.sv ----
`default_nettype none

package hrp_pkg;

  // ----------------------------------------
  // Device end access phase
  // ----------------------------------------
  typedef enum logic [1:0] {
    HRP_DEV_IDLE = 2'b00,
    HRP_DEV_READ = 2'b01,
    HRP_DEV_WRITE = 2'b10
  } hrp_dev_phase_t;

  // ----------------------------------------
  // Host end access phase
  // ----------------------------------------
  typedef enum logic [1:0] {
    HRP_HOST_IDLE = 2'b00,
    HRP_HOST_SETUP = 2'b01,
    HRP_HOST_STROBE = 2'b11,
    HRP_HOST_HOLD = 2'b10
  } hrp_host_phase_t;

endpackage

`default_nettype wire

// ---- verilog/hrp_bus_if.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "hrp_params.svh"

interface hrp_bus_if;
  // ----------------------------------------
  // Host driven pins
  // ----------------------------------------
  logic chip_select_n;
  logic read_strobe_n;
  logic write_strobe_n;
  logic bus_style_select;
  logic [`HRP_ADDR_W-1:0] addr;
  logic [`HRP_DATA_W-1:0] host_data;
  logic host_oe;

  // ----------------------------------------
  // Device driven pins
  // ----------------------------------------
  logic [`HRP_DATA_W-1:0] dev_data;
  logic dev_oe;

  // ----------------------------------------
  // Resolved shared data bus, pulled high when idle
  // ----------------------------------------
  logic [`HRP_DATA_W-1:0] data_bus;
  assign data_bus = dev_oe ? dev_data : (host_oe ? host_data : `HRP_BUS_IDLE); // R1

  modport dev (
    input chip_select_n,
    input read_strobe_n,
    input write_strobe_n,
    input bus_style_select,
    input addr,
    input data_bus,
    output dev_data,
    output dev_oe
  );

  modport host (
    output chip_select_n,
    output read_strobe_n,
    output write_strobe_n,
    output bus_style_select,
    output addr,
    output host_data,
    output host_oe,
    input data_bus
  );
endinterface

`default_nettype wire

// ---- verilog/hrp_host.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "hrp_params.svh"

module hrp_host
  import hrp_pkg::*;
#(
  parameter int DATA_W = `HRP_DATA_W,
  parameter int ADDR_W = `HRP_ADDR_W,
  parameter int SETUP_CYC = `HRP_SETUP_CYC,
  parameter int STROBE_CYC = `HRP_STROBE_CYC,
  parameter int HOLD_CYC = `HRP_HOLD_CYC,
  parameter logic BUS_STYLE = `HRP_STYLE_SEPARATE
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Device facing pins
  hrp_bus_if.host bus,
  // Command port
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [DATA_W-1:0] cmd_wdata,
  output logic cmd_ready,
  // Response port
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata
);

  // ----------------------------------------
  // Parameter checks
  // ----------------------------------------
  if (SETUP_CYC < 1 || SETUP_CYC > 256 || HOLD_CYC < 1 || HOLD_CYC > 256) begin : g_bad_timing
    $error("hrp_host: setup and hold must be 1 to 256 cycles");
  end
  if (STROBE_CYC < `HRP_STROBE_MIN || STROBE_CYC > 256) begin : g_bad_strobe
    $error("hrp_host: strobe must be 2 to 256 cycles");
  end

  localparam logic [7:0] SETUP_LD = 8'(SETUP_CYC - 1);
  localparam logic [7:0] STROBE_LD = 8'(STROBE_CYC - 1);
  localparam logic [7:0] HOLD_LD = 8'(HOLD_CYC - 1);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    hrp_host_phase_t phase;
    logic [7:0] count;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic data_oe;
    logic ready;
    logic rsp_valid;
  } hrp_host_state_t;

  hrp_host_state_t s;
  hrp_host_state_t next_s;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_s = s;
    next_s.rsp_valid = 1'b0;
    case (s.phase)
      HRP_HOST_IDLE: begin
        if (cmd_valid && s.ready) begin
          next_s.phase = HRP_HOST_SETUP;
          next_s.count = SETUP_LD;
          next_s.write = cmd_write;
          next_s.addr = cmd_addr; // R7
          next_s.wdata = cmd_wdata;
          next_s.cs_n = 1'b0; // R3
          next_s.data_oe = cmd_write; // R1
          next_s.wr_n = (BUS_STYLE == `HRP_STYLE_COMBINED) ? !cmd_write : 1'b1; // R8
          next_s.ready = 1'b0;
        end
      end
      HRP_HOST_SETUP: begin
        if (s.count == 8'h00) begin
          next_s.phase = HRP_HOST_STROBE;
          next_s.count = STROBE_LD;
          // Combined style strobes the read pin for both directions
          next_s.rd_n = (BUS_STYLE == `HRP_STYLE_COMBINED) ? 1'b0 : s.write; // R8
          next_s.wr_n = !s.write; // R8
        end else begin
          next_s.count = s.count - 8'h01;
        end
      end
      HRP_HOST_STROBE: begin
        if (s.count == 8'h00) begin
          next_s.phase = HRP_HOST_HOLD;
          next_s.count = HOLD_LD;
          if (!s.write) begin
            next_s.rdata = bus.data_bus; // R4 R2
          end
          next_s.rd_n = 1'b1;
          // Rising write strobe in the separate style, with chip select and data still held
          next_s.wr_n = (BUS_STYLE == `HRP_STYLE_COMBINED) ? !s.write : 1'b1; // R5
        end else begin
          next_s.count = s.count - 8'h01;
        end
      end
      HRP_HOST_HOLD: begin
        if (s.count == 8'h00) begin
          next_s.phase = HRP_HOST_IDLE;
          next_s.cs_n = 1'b1; // R3
          next_s.data_oe = 1'b0;
          next_s.wr_n = 1'b1;
          next_s.ready = 1'b1;
          next_s.rsp_valid = 1'b1;
        end else begin
          next_s.count = s.count - 8'h01;
        end
      end
      default: begin
        next_s.phase = HRP_HOST_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s.phase <= HRP_HOST_IDLE;
      s.count <= 8'h00;
      s.write <= 1'b0;
      s.addr <= '0;
      s.wdata <= '0;
      s.rdata <= '0;
      s.cs_n <= 1'b1;
      s.rd_n <= 1'b1;
      s.wr_n <= 1'b1;
      s.data_oe <= 1'b0;
      s.ready <= 1'b1;
      s.rsp_valid <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign bus.chip_select_n = s.cs_n;
  assign bus.read_strobe_n = s.rd_n;
  assign bus.write_strobe_n = s.wr_n;
  assign bus.bus_style_select = BUS_STYLE; // R8
  assign bus.addr = s.addr;
  assign bus.host_data = s.wdata;
  assign bus.host_oe = s.data_oe;
  assign cmd_ready = s.ready;
  assign rsp_valid = s.rsp_valid;
  assign rsp_rdata = s.rdata;

endmodule

`default_nettype wire

// ---- test/hrp_bus_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "hrp_params.svh"

module hrp_bus_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Host driven pins
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic bus_style_select,
  input wire logic [`HRP_ADDR_W-1:0] addr,
  input wire logic [`HRP_DATA_W-1:0] host_data,
  input wire logic host_oe,
  // Device driven pins
  input wire logic dev_oe
);
  // ----------------------------------------
  // Qualified read as seen on the pins
  // ----------------------------------------
  logic rd_q;
  assign rd_q = !chip_select_n && !read_strobe_n && (!bus_style_select || write_strobe_n);

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_oe_on_read;
    rd_q |=> dev_oe;
  endproperty
  a_oe_on_read: assert property (p_oe_on_read) else $error("device did not drive a read");

  property p_oe_release;
    !rd_q |=> !dev_oe;
  endproperty
  a_oe_release: assert property (p_oe_release) else $error("device held bus outside read");

  property p_no_fight;
    !(dev_oe && host_oe);
  endproperty
  a_no_fight: assert property (p_no_fight) else $error("both ends drive data bus");

  property p_strobe_cs;
    (!read_strobe_n || (!bus_style_select && !write_strobe_n)) |-> !chip_select_n;
  endproperty
  a_strobe_cs: assert property (p_strobe_cs) else $error("strobe without chip select");

  property p_addr_hold;
    (!chip_select_n && $past(chip_select_n) == 1'b0) |-> $stable(addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved in access");

  property p_cs_frame;
    $fell(chip_select_n) |-> !chip_select_n [*6] ##1 chip_select_n;
  endproperty
  a_cs_frame: assert property (p_cs_frame) else $error("chip select frame length wrong");

  property p_rd_len;
    $fell(read_strobe_n) |-> !read_strobe_n [*4] ##1 (read_strobe_n && !chip_select_n);
  endproperty
  a_rd_len: assert property (p_rd_len) else $error("read strobe length wrong");

  property p_wr_len;
    ($fell(write_strobe_n) && !bus_style_select) |-> !write_strobe_n [*4] ##1 (write_strobe_n && !chip_select_n);
  endproperty
  a_wr_len: assert property (p_wr_len) else $error("write strobe length wrong");

  property p_wr_data;
    ($rose(write_strobe_n) && !chip_select_n && !bus_style_select) |-> host_oe && $stable(host_data);
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("write data not held at strobe rise");
endmodule

`default_nettype wire

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "hrp_params.svh"

`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin error_cnt++; $display("BAD t=%0t got %h exp %h", $time, got, exp); end end

module tb_top;
  import hrp_pkg::*;
  // ----------------------------------------
  // Clock, reset and stimulus
  // ----------------------------------------
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  logic [12:0] cmd_addr = 13'h0000;
  logic [7:0] cmd_wdata = 8'h00;
  logic cmd_ready, rsp_valid;
  logic [7:0] rsp_rdata, user_rd_data, host_wr_data;
  logic user_wr_valid = 1'b0;
  logic [12:0] user_wr_addr = 13'h0000;
  logic [7:0] user_wr_data = 8'h00;
  logic [12:0] user_rd_addr = 13'h0000;
  logic host_wr_valid, host_rd_valid;
  logic [12:0] host_wr_addr, host_rd_addr;
  logic cmd_ready_m, rsp_valid_m, host_wr_valid_m, host_rd_valid_m;
  logic [7:0] rsp_rdata_m, user_rd_data_m, host_wr_data_m;
  logic [12:0] host_wr_addr_m, host_rd_addr_m;
  logic [7:0] mem [0:255];
  int error_cnt = 0;
  int n_tests = 0;

  initial begin
    forever #12.5 core_clk = ~core_clk;
  end

  // ----------------------------------------
  // Both ends and the checker
  // ----------------------------------------
  hrp_bus_if bus();
  hrp_host u_hrp_host (.core_clk(core_clk), .rst_n(rst_n), .bus(bus), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
  hrp_device u_hrp_device (.core_clk(core_clk), .rst_n(rst_n), .bus(bus), .user_wr_valid(user_wr_valid),
    .user_wr_addr(user_wr_addr), .user_wr_data(user_wr_data), .user_rd_addr(user_rd_addr),
    .user_rd_data(user_rd_data), .host_wr_valid(host_wr_valid), .host_wr_addr(host_wr_addr),
    .host_wr_data(host_wr_data), .host_rd_valid(host_rd_valid), .host_rd_addr(host_rd_addr));
  // Second pair in the combined strobe style, fed the same commands
  hrp_bus_if bus_m();
  hrp_host #(.BUS_STYLE(`HRP_STYLE_COMBINED)) u_hrp_host_m (.core_clk(core_clk), .rst_n(rst_n), .bus(bus_m),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_ready(cmd_ready_m), .rsp_valid(rsp_valid_m), .rsp_rdata(rsp_rdata_m));
  hrp_device u_hrp_device_m (.core_clk(core_clk), .rst_n(rst_n), .bus(bus_m), .user_wr_valid(user_wr_valid),
    .user_wr_addr(user_wr_addr), .user_wr_data(user_wr_data), .user_rd_addr(user_rd_addr),
    .user_rd_data(user_rd_data_m), .host_wr_valid(host_wr_valid_m), .host_wr_addr(host_wr_addr_m),
    .host_wr_data(host_wr_data_m), .host_rd_valid(host_rd_valid_m), .host_rd_addr(host_rd_addr_m));
  hrp_bus_chk u_hrp_bus_chk (.core_clk(core_clk), .rst_n(rst_n), .chip_select_n(bus.chip_select_n),
    .read_strobe_n(bus.read_strobe_n), .write_strobe_n(bus.write_strobe_n),
    .bus_style_select(bus.bus_style_select), .addr(bus.addr), .host_data(bus.host_data),
    .host_oe(bus.host_oe), .dev_oe(bus.dev_oe));

  // ----------------------------------------
  // Expectations and tasks
  // ----------------------------------------
  function automatic logic [7:0] exp_rd(input logic [12:0] a);
    if (a < 13'h0100) begin
      return mem[a[7:0]];
    end
    return 8'h00;
  endfunction

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic op(input logic w, input logic [12:0] a, input logic [7:0] d);
    logic [7:0] seen;
    logic rd_seen;
    logic wr_seen;
    logic [7:0] seen_m;
    logic rd_seen_m;
    logic wr_seen_m;
    logic busy;
    int n;
    seen = 8'hxx;
    rd_seen = 1'b0;
    wr_seen = 1'b0;
    seen_m = 8'hxx;
    rd_seen_m = 1'b0;
    wr_seen_m = 1'b0;
    busy = 1'b1;
    n = 0;
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
      if (bus.dev_oe === 1'b1) seen = bus.data_bus;
      if (host_rd_valid === 1'b1) rd_seen = (host_rd_addr === a);
      if (host_wr_valid === 1'b1) wr_seen = (host_wr_addr === a) && (host_wr_data === d);
      if (bus_m.dev_oe === 1'b1) seen_m = bus_m.data_bus;
      if (host_rd_valid_m === 1'b1) rd_seen_m = (host_rd_addr_m === a);
      if (host_wr_valid_m === 1'b1) wr_seen_m = (host_wr_addr_m === a) && (host_wr_data_m === d);
      if (n == 1) busy = cmd_ready;
    end while (rsp_valid !== 1'b1 && n < 20);
    `CHK(rsp_valid, 1'b1)
    `CHK(busy, 1'b0)
    `CHK(cmd_ready, 1'b1)
    `CHK(rsp_valid_m, 1'b1)
    `CHK(cmd_ready_m, 1'b1)
    if (w) begin
      `CHK(wr_seen, 1'b1)
      `CHK(wr_seen_m, 1'b1)
      if (a < 13'h0100) mem[a[7:0]] = d;
    end else begin
      `CHK(rsp_rdata, exp_rd(a))
      `CHK(seen, exp_rd(a))
      `CHK(rd_seen, 1'b1)
      `CHK(bus.dev_oe, 1'b0)
      `CHK(rsp_rdata_m, exp_rd(a))
      `CHK(seen_m, exp_rd(a))
      `CHK(rd_seen_m, 1'b1)
      `CHK(bus_m.dev_oe, 1'b0)
    end
  endtask

  task automatic lw(input logic [12:0] a, input logic [7:0] d);
    @(posedge core_clk);
    user_wr_valid <= 1'b1;
    user_wr_addr <= a;
    user_wr_data <= d;
    @(posedge core_clk);
    user_wr_valid <= 1'b0;
    if (a < 13'h0100) mem[a[7:0]] = d;
  endtask

  task automatic lr(input logic [12:0] a);
    @(posedge core_clk);
    user_rd_addr <= a;
    repeat (2) @(posedge core_clk);
    #1;
    `CHK(user_rd_data, exp_rd(a))
    `CHK(user_rd_data_m, exp_rd(a))
  endtask

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  initial begin
    #(25 * 5000);
    error_cnt++;
    $display("BAD t=%0t watchdog expired", $time);
    conclude();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [12:0] bounds [4];
    bounds = '{13'h0000, 13'h00ff, 13'h0100, 13'h1fff};
    foreach (mem[i]) mem[i] = 8'h00;
    void'($urandom(32'h7965aa0b));
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    op(1'b1, 13'h0010, 8'ha5);
    op(1'b0, 13'h0010, 8'h00);
    $display("test basic done");
    for (int i = 0; i < 8; i++) begin
      op(1'b1, 13'(i), 8'h01 << i);
      op(1'b0, 13'(i), 8'h00);
      lr(13'(i));
    end
    $display("test bit order done");
    foreach (bounds[i]) begin
      op(1'b1, bounds[i], ~bounds[i][7:0]);
      op(1'b0, bounds[i], 8'h00);
    end
    $display("test address bounds done");
    lw(13'h0042, 8'h3c);
    op(1'b0, 13'h0042, 8'h00);
    lw(13'h0123, 8'h77);
    op(1'b0, 13'h0123, 8'h00);
    $display("test local write done");
    repeat (40) begin
      op(1'($urandom), 13'($urandom % 300), 8'($urandom));
    end
    $display("test random done");
    conclude();
  end
endmodule

`default_nettype wire
